// ---- verilog/tpu_pwm_timer.sv ----
// Purpose: 16-bit PWM timer channel, center or edge aligned
// Assumes: AXI4-Lite slave on sys_clk_i, synchronous reset
// Notes: Compare writes are buffered until the period boundary

`timescale 1ns/100ps
`default_nettype none

module tpu_pwm_timer import tpu_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [TPU_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [TPU_DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [TPU_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [TPU_DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic pwm_o
);

  // ==========================================================
  // Declarations
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [TPU_ADDR_W-1:0] awaddr_r, awaddr_nxt, waddr;
  logic [TPU_DATA_W-1:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic arready_r, arready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [TPU_DATA_W-1:0] rdata_r, rdata_nxt;
  tpu_ctrl_t ctrl_r, ctrl_nxt;
  logic [TPU_CNT_W-1:0] mod_r, mod_nxt, cvb_r, cvb_nxt;
  logic [TPU_CNT_W-1:0] cnt_r, cnt_nxt, cva_r, cva_nxt;
  tpu_dir_t dir_r, dir_nxt;
  logic skip_r, skip_nxt, pwm_r, pwm_nxt;
  logic cnt_wr, run, tick, pstart;

  // ==========================================================
  // Prescaler
  assign run = ctrl_r.clk_sel != 2'h0;

  tpu_prescaler u_prescaler (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .clr_i(cnt_wr),
    .ps_i(ctrl_r.ps),
    .tick_o(tick)
  );

  // ==========================================================
  // Register write path
  assign waddr = {awaddr_r[TPU_ADDR_W-1:2], 2'b00};

  always_comb begin
    aw_full_nxt = aw_full_r;
    awaddr_nxt = awaddr_r;
    w_full_nxt = w_full_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    mod_nxt = mod_r;
    cvb_nxt = cvb_r;
    cnt_wr = 1'b0;
    if (s_axi_awvalid_i && awready_r) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_r) begin
      w_full_nxt = 1'b1;
      wdata_nxt = s_axi_wdata_i;
      wstrb_nxt = s_axi_wstrb_i;
    end
    if (bvalid_r && s_axi_bready_i) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_full_r && w_full_r && !bvalid_r) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = TPU_RESP_OKAY;
      case (waddr)
        TPU_OFS_CTRL: begin
          if (wstrb_r[0]) begin
            ctrl_nxt = tpu_ctrl_t'(wdata_r[TPU_CTRL_W-1:0]);
          end
        end
        TPU_OFS_COUNT: begin
          cnt_wr = 1'b1;
        end
        TPU_OFS_MOD: begin
          if (wstrb_r[0]) begin
            mod_nxt[7:0] = wdata_r[7:0];
          end
          if (wstrb_r[1]) begin
            mod_nxt[15:8] = wdata_r[15:8];
          end
        end
        TPU_OFS_CV: begin
          if (wstrb_r[0]) begin
            cvb_nxt[7:0] = wdata_r[7:0];
          end
          if (wstrb_r[1]) begin
            cvb_nxt[15:8] = wdata_r[15:8];
          end
        end
        TPU_OFS_STAT: begin
          bresp_nxt = TPU_RESP_OKAY;
        end
        default: begin
          bresp_nxt = TPU_RESP_SLVERR;
        end
      endcase
    end
    awready_nxt = !aw_full_nxt;
    wready_nxt = !w_full_nxt;
  end

  // ==========================================================
  // Register read path
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready_i) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid_i && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = TPU_RESP_OKAY;
      rdata_nxt = '0;
      case ({s_axi_araddr_i[TPU_ADDR_W-1:2], 2'b00})
        TPU_OFS_CTRL: begin
          rdata_nxt[TPU_CTRL_W-1:0] = ctrl_r;
        end
        TPU_OFS_COUNT: begin
          rdata_nxt[TPU_CNT_W-1:0] = cnt_r;
        end
        TPU_OFS_MOD: begin
          rdata_nxt[TPU_CNT_W-1:0] = mod_r;
        end
        TPU_OFS_CV: begin
          rdata_nxt[TPU_CNT_W-1:0] = cvb_r;
        end
        TPU_OFS_STAT: begin
          rdata_nxt[TPU_STAT_OUT_BIT] = pwm_r;
          rdata_nxt[TPU_STAT_DIR_BIT] = dir_r == DIR_DOWN;
          rdata_nxt[TPU_STAT_SKIP_BIT] = skip_r;
          rdata_nxt[TPU_STAT_CVA_LSB +: TPU_CNT_W] = cva_r;
        end
        default: begin
          rresp_nxt = TPU_RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  // ==========================================================
  // Counter, compare load and output
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    cva_nxt = cva_r;
    skip_nxt = skip_r;
    pstart = 1'b0;
    if (cnt_wr) begin
      // Clear also restarts the direction, as after reset
      cnt_nxt = TPU_CNT_RST;
      dir_nxt = DIR_DOWN;
    end else if (run && tick) begin
      if (ctrl_r.center) begin
        case (dir_r)
          DIR_DOWN: begin
            if (cnt_r == 16'h0000) begin
              if (mod_r != 16'h0000) begin
                cnt_nxt = 16'h0001;
                dir_nxt = DIR_UP;
              end else begin
                pstart = 1'b1;
              end
            end else begin
              cnt_nxt = cnt_r - 16'h0001;
            end
          end
          DIR_UP: begin
            if ({1'b0, cnt_r} + 17'h00001 >= {1'b0, mod_r}) begin
              cnt_nxt = mod_r;
              dir_nxt = DIR_DOWN;
              pstart = 1'b1;
            end else begin
              cnt_nxt = cnt_r + 16'h0001;
            end
          end
          default: begin
            dir_nxt = DIR_DOWN;
          end
        endcase
      end else begin
        dir_nxt = DIR_UP;
        if (cnt_r >= mod_r) begin
          cnt_nxt = 16'h0000;
          pstart = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
    end
    if (pstart) begin
      if (!ctrl_r.center && cva_r == 16'h0000 && cvb_r != 16'h0000 &&
          !skip_r) begin
        skip_nxt = 1'b1;
      end else begin
        cva_nxt = cvb_r;
        skip_nxt = 1'b0;
      end
    end
    if (cva_nxt == 16'h0000 || cva_nxt[TPU_CNT_W-1]) begin
      pwm_nxt = 1'b0;
    end else if (ctrl_nxt.center) begin
      pwm_nxt = (cnt_nxt < cva_nxt) ||
        (cnt_nxt == cva_nxt && dir_nxt == DIR_DOWN);
    end else begin
      pwm_nxt = cnt_nxt < cva_nxt;
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_full_r <= 1'b0;
      awaddr_r <= '0;
      w_full_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= TPU_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= TPU_RESP_OKAY;
      rdata_r <= '0;
      ctrl_r <= TPU_CTRL_RST;
      mod_r <= TPU_MOD_RST;
      cvb_r <= TPU_CV_RST;
      cva_r <= TPU_CV_RST;
      cnt_r <= TPU_CNT_RST;
      dir_r <= DIR_DOWN;
      skip_r <= 1'b0;
      pwm_r <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      awaddr_r <= awaddr_nxt;
      w_full_r <= w_full_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      mod_r <= mod_nxt;
      cvb_r <= cvb_nxt;
      cva_r <= cva_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      skip_r <= skip_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;
  assign pwm_o = pwm_r;

  // ==========================================================
  // Assertions
  a_zero_neg_out: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (cva_r[TPU_CNT_W-1] || cva_r == 16'h0000) |-> !pwm_r)
    else $error("output active with zero or negative compare");

  a_full_duty: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_r.center && cva_r == mod_r && cva_r != 16'h0000 &&
     !cva_r[TPU_CNT_W-1] && cnt_r <= mod_r) |-> pwm_r)
    else $error("full duty output went inactive");

  a_near_full: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_r.center && cva_r == mod_r - 16'h0001 && cva_r != 16'h0000 &&
     !cva_r[TPU_CNT_W-1] && dir_r == DIR_DOWN && cnt_r == cva_r)
    |-> pwm_r)
    else $error("near full duty collapsed");

  a_period_load: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !$stable(cva_r) |->
    ($past(ctrl_r.center) ? cnt_r == mod_r : cnt_r == 16'h0000))
    else $error("compare loaded away from period boundary");

  a_stop_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_r.clk_sel == 2'h0 && !cnt_wr) |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  a_count_clear: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    cnt_wr |=> (cnt_r == 16'h0000 && dir_r == DIR_DOWN))
    else $error("count write did not clear count");

  a_turn_up: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_r.center && run && tick && !cnt_wr && dir_r == DIR_DOWN &&
     cnt_r == 16'h0000 && mod_r != 16'h0000)
    |=> (dir_r == DIR_UP && cnt_r == 16'h0001))
    else $error("counter did not turn up at zero");

  a_edge_late: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (!ctrl_r.center && run && tick && !cnt_wr && cnt_r >= mod_r &&
     cva_r == 16'h0000 && cvb_r != 16'h0000 && !skip_r)
    |=> (cva_r == 16'h0000 && skip_r && !pwm_r))
    else $error("edge mode zero to nonzero not delayed");

endmodule

`default_nettype wire

// ---- verilog/tpu_pkg.sv ----
// Purpose: Shared constants and types for the PWM timer channel
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: Offsets are byte addresses

`default_nettype none

package tpu_pkg;

  // ==========================================================
  // Widths
  localparam int TPU_ADDR_W = 8;
  localparam int TPU_DATA_W = 32;
  localparam int TPU_CNT_W = 16;
  localparam int TPU_PS_W = 3;
  localparam int TPU_DIV_W = 7;
  localparam int TPU_CTRL_W = 6;

  // ==========================================================
  // Register offsets
  localparam logic [TPU_ADDR_W-1:0] TPU_OFS_CTRL = 8'h00;
  localparam logic [TPU_ADDR_W-1:0] TPU_OFS_COUNT = 8'h04;
  localparam logic [TPU_ADDR_W-1:0] TPU_OFS_MOD = 8'h08;
  localparam logic [TPU_ADDR_W-1:0] TPU_OFS_CV = 8'h0c;
  localparam logic [TPU_ADDR_W-1:0] TPU_OFS_STAT = 8'h10;

  // ==========================================================
  // Status field positions
  localparam int TPU_STAT_OUT_BIT = 0;
  localparam int TPU_STAT_DIR_BIT = 1;
  localparam int TPU_STAT_SKIP_BIT = 2;
  localparam int TPU_STAT_CVA_LSB = 16;

  // ==========================================================
  // Reset values
  localparam logic [TPU_CNT_W-1:0] TPU_CNT_RST = 16'h0000;
  localparam logic [TPU_CNT_W-1:0] TPU_MOD_RST = 16'hffff;
  localparam logic [TPU_CNT_W-1:0] TPU_CV_RST = 16'h0000;

  // ==========================================================
  // Bus response codes
  localparam logic [1:0] TPU_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPU_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic center;
    logic [1:0] clk_sel;
    logic [TPU_PS_W-1:0] ps;
  } tpu_ctrl_t;

  localparam tpu_ctrl_t TPU_CTRL_RST = '0;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } tpu_dir_t;

endpackage

`default_nettype wire

// ---- verilog/tpu_prescaler.sv ----
// Purpose: Power-of-two prescaler giving the timer count tick
// Assumes: Runs on the bus clock
// Notes: Restarts from zero on a count clear

`timescale 1ns/100ps
`default_nettype none

module tpu_prescaler import tpu_pkg::*; #(
  parameter int PS_W = TPU_PS_W,
  parameter int DIV_W = TPU_DIV_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic clr_i,
  input wire logic [PS_W-1:0] ps_i,
  output logic tick_o
);

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [DIV_W-1:0] mask;

  // ==========================================================
  // Divider
  always_comb begin
    mask = ~({DIV_W{1'b1}} << ps_i);
    div_nxt = div_r;
    if (clr_i) begin
      div_nxt = '0;
    end else if (run_i) begin
      div_nxt = div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Setting 3'h1 ticks every second clock
  assign tick_o = run_i && ((div_r | ~mask) == {DIV_W{1'b1}});

  a_half_rate: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ps_i == 3'h1 && run_i && !clr_i && tick_o) |=> !tick_o)
    else $error("prescale by two ticked twice in a row");

endmodule

`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the PWM timer channel
// Assumes: AXI4-Lite master tasks, bready and rready held high
// Notes: Duty is measured by counting high cycles of pwm_o

`timescale 1ns/100ps
`default_nettype none

module tb import tpu_pkg::*; ();
  logic sys_clk_i;
  logic rst_i;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic awvalid, wvalid, arvalid, bready, rready;
  logic awready, wready, bvalid, arready, rvalid, pwm;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [3:0] wstrb;
  logic [31:0] d;
  logic [31:0] ca;
  logic [1:0] r;
  logic [1:0] seen;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int h;
  logic [31:0] cvs [6] = '{32'h3, 32'h8, 32'h9, 32'h7, 32'h6, 32'h8000};
  int exp_h [6] = '{24, 64, 64, 56, 48, 0};

  tpu_pwm_timer i_dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .pwm_o(pwm)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("[FAIL] %0t timeout", $time);
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Bus and measurement tasks
  task automatic tally_and_finish();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge sys_clk_i);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    @(posedge sys_clk_i);
    while (bvalid !== 1'b1) @(posedge sys_clk_i);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge sys_clk_i);
    while (arready !== 1'b1) @(posedge sys_clk_i);
    arvalid <= 1'b0;
    @(posedge sys_clk_i);
    while (rvalid !== 1'b1) @(posedge sys_clk_i);
    d = rdata;
    r = rresp;
  endtask

  task automatic meas(input int n);
    h = 0;
    repeat (n) begin
      @(posedge sys_clk_i);
      if (pwm === 1'b1) h++;
    end
  endtask

  task automatic wait_dir(input logic v);
    rd(TPU_OFS_STAT);
    while (d[TPU_STAT_DIR_BIT] !== ~v) rd(TPU_OFS_STAT);
    while (d[TPU_STAT_DIR_BIT] !== v) rd(TPU_OFS_STAT);
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    rst_i = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    wstrb = 4'hf;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(TPU_OFS_CTRL);
    chk(d, 32'h0, "ctrl reset");
    chk(32'(r), 32'(TPU_RESP_OKAY), "rd okay");
    rd(TPU_OFS_MOD);
    chk(d, 32'hffff, "mod reset");
    rd(TPU_OFS_CV);
    chk(d, 32'h0, "cv reset");
    rd(8'h14);
    chk(32'(r), 32'(TPU_RESP_SLVERR), "rd unmapped");
    wr(8'h14, 32'h1);
    chk(32'(r), 32'(TPU_RESP_SLVERR), "wr unmapped");
    wstrb <= 4'h1;
    wr(TPU_OFS_MOD, 32'h1234);
    wstrb <= 4'hf;
    rd(TPU_OFS_MOD);
    chk(d, 32'hff34, "mod byte strobe");
    repeat (20) @(posedge sys_clk_i);
    rd(TPU_OFS_COUNT);
    chk(d, 32'h0, "stopped count");
    wr(TPU_OFS_MOD, 32'h9);
    chk(32'(r), 32'(TPU_RESP_OKAY), "wr okay");
    wr(TPU_OFS_CV, 32'h3);
    wr(TPU_OFS_CTRL, 32'h8);
    meas(16);
    chk(h, 0, "edge extra zero period");
    rd(TPU_OFS_STAT);
    chk(32'(d[TPU_STAT_SKIP_BIT]), 32'h1, "skip pending");
    meas(40);
    chk(h, 12, "edge duty");
    wr(TPU_OFS_CTRL, 32'h0);
    rd(TPU_OFS_COUNT);
    ca = d;
    repeat (10) @(posedge sys_clk_i);
    rd(TPU_OFS_COUNT);
    chk(d, ca, "count frozen");
    wr(TPU_OFS_COUNT, 32'h1234);
    rd(TPU_OFS_COUNT);
    chk(d, 32'h0, "count clear");
    wr(TPU_OFS_CTRL, 32'h8);
    repeat (5) @(posedge sys_clk_i);
    rd(TPU_OFS_COUNT);
    chk(32'(d != 32'h0), 32'h1, "count resumes");
    for (int i = 0; i < 2; i++) begin
      wr(TPU_OFS_CV, (i == 0) ? 32'h8000 : 32'hffff);
      repeat (30) @(posedge sys_clk_i);
      meas(40);
      chk(h, 0, "negative compare");
    end
    wr(TPU_OFS_CTRL, 32'h1);
    wr(TPU_OFS_CV, 32'h3);
    wr(TPU_OFS_COUNT, 32'h0);
    wr(TPU_OFS_CTRL, 32'h9);
    repeat (60) @(posedge sys_clk_i);
    meas(80);
    chk(h, 24, "prescale by two");
    wr(TPU_OFS_CTRL, 32'h20);
    wr(TPU_OFS_MOD, 32'h8);
    wr(TPU_OFS_COUNT, 32'h0);
    wr(TPU_OFS_CTRL, 32'h28);
    for (int i = 0; i < 6; i++) begin
      wr(TPU_OFS_CV, cvs[i]);
      repeat (40) @(posedge sys_clk_i);
      meas(64);
      chk(h, exp_h[i], "center duty");
    end
    seen = 2'b00;
    for (int i = 0; i < 12; i++) begin
      rd(TPU_OFS_COUNT);
      chk(32'(d <= 32'h8), 32'h1, "count range");
      rd(TPU_OFS_STAT);
      seen[d[TPU_STAT_DIR_BIT]] = 1'b1;
    end
    chk(32'(seen), 32'h3, "both directions");
    wr(TPU_OFS_MOD, 32'h28);
    wr(TPU_OFS_CV, 32'h0);
    repeat (200) @(posedge sys_clk_i);
    wait_dir(1'b1);
    wr(TPU_OFS_CV, 32'h3);
    rd(TPU_OFS_STAT);
    chk(32'(d[TPU_STAT_CVA_LSB +: 16]), 32'h0, "compare held");
    meas(40);
    chk(h, 0, "no start mid period");
    repeat (100) @(posedge sys_clk_i);
    rd(TPU_OFS_STAT);
    chk(32'(d[TPU_STAT_CVA_LSB +: 16]), 32'h3, "compare loaded");
    wr(TPU_OFS_CV, 32'h14);
    repeat (200) @(posedge sys_clk_i);
    wait_dir(1'b0);
    wr(TPU_OFS_CV, 32'h0);
    meas(8);
    chk(h, 8, "old duty kept");
    repeat (100) @(posedge sys_clk_i);
    meas(80);
    chk(h, 0, "zero duty after period");
    tally_and_finish();
  end
endmodule

`default_nettype wire
